// ---- logic/codec_power_instruction_memory.sv ----
// power control, gain decode and instruction memory interface registers
`timescale 1ns/1ps
`default_nettype none
module codec_power_instruction_memory
	import codec_regs_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire serial_req_s                 req,
	output logic                             rd_valid,
	output logic [11:0]                      rd_data,
	input  wire gain_codes_s                 gains,
	output logic [STAGES-1:0]                stage_on,
	output logic [STAGES*MULT_W-1:0]         stage_mult,
	input  wire logic                        receive_on_pin,
	input  wire logic                        transmit_on_pin,
	output logic [SECTIONS-1:0]              section_en,
	input  wire logic [PTR_W-1:0]            vp_fetch_addr,
	output logic [INSTR_W-1:0]               vp_instr,
	input  wire logic                        vp_xword_we,
	input  wire logic [XWORD_W-1:0]          vp_xword_wdata,
	output logic [XWORD_W-1:0]               vp_xword,
	output logic                             vp_restart
);
	logic [SECTIONS-1:0]        power_reg;
	logic [SECTIONS-1:0]        power_next;
	logic [PTR_W-1:0]           ptr_reg;
	logic [XWORD_W-1:0]         xword_reg;
	logic [BYTE_W-1:0]          low_reg;
	logic [BYTE_W-1:0]          high_reg;
	logic [INSTR_W-1:0]         lag_reg;
	logic [INSTR_W-1:0]         mem [MEM_DEPTH];
	logic                       voice_was_on_reg;

	// serial decode; only voice_on, mem_wr_ok and dev_on depend on power state
	wire        wr_en     = req.valid & req.write;
	wire        rd_en     = req.valid & ~req.write;
	wire        hit_power = req.addr == ADDR_POWER;
	wire        hit_ramif = req.addr == ADDR_RAMIF;
	wire [3:0]  psub      = req.data[PSUB_MSB:PSUB_LSB];
	wire [1:0]  rsub      = req.data[RSUB_MSB:RSUB_LSB];
	wire        pwr_bit   = req.data[POWER_BIT];
	wire        voice_on  = power_reg[SEC_VOICE_TX] | power_reg[SEC_VOICE_RX];
	wire        mem_wr_ok = ~voice_on;
	wire        ram_wr    = wr_en & hit_ramif;
	wire        ram_rd    = rd_en & hit_ramif;
	wire        wr_low    = ram_wr & (rsub == RSUB_LOW);
	wire        wr_high   = ram_wr & (rsub == RSUB_HIGH);
	wire        wr_ptr    = ram_wr & (rsub == RSUB_PTR);
	wire        wr_xword  = ram_wr & (rsub == RSUB_XWORD);
	wire        rd_byte   = ram_rd & ~rsub[1];
	wire        dev_on    = power_reg[SEC_DEVICE];

	// section select; unknown codes leave power untouched
	always_comb begin
		power_next = power_reg;
		if (wr_en && hit_power) begin
			case (psub)
				PSUB_GAIN_DAC: power_next[SEC_GAIN_DAC] = pwr_bit;
				PSUB_FREQ_DAC: power_next[SEC_FREQ_DAC] = pwr_bit;
				PSUB_RAMP_DAC: power_next[SEC_RAMP_DAC] = pwr_bit;
				PSUB_VOICE_TX: power_next[SEC_VOICE_TX] = pwr_bit;
				PSUB_VOICE_RX: power_next[SEC_VOICE_RX] = pwr_bit;
				PSUB_REF:      power_next[SEC_REF]      = pwr_bit;
				PSUB_BB_RX:    power_next[SEC_BB_RX]    = pwr_bit;
				PSUB_BB_TX:    power_next[SEC_BB_TX]    = pwr_bit;
				PSUB_DEVICE:   power_next[SEC_DEVICE]   = pwr_bit;
				default:       power_next = power_reg;
			endcase
		end
	end

	// read data selection
	logic [11:0] rd_mux;
	always_comb begin
		rd_mux = 12'h000;
		if (hit_ramif) begin
			case (rsub)
				RSUB_LOW:   rd_mux = {4'h0, lag_reg[BYTE_W-1:0]};
				RSUB_HIGH:  rd_mux = {4'h0, lag_reg[INSTR_W-1:BYTE_W]};
				RSUB_PTR:   rd_mux = {3'h0, ptr_reg};
				RSUB_XWORD: rd_mux = {2'h0, xword_reg};
				default:    rd_mux = 12'h000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			power_reg <= POWER_RESET;
		end else begin
			power_reg <= power_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data  <= 12'h000;
		end else begin
			rd_valid <= rd_en;
			rd_data  <= rd_en ? rd_mux : 12'h000;
		end
	end

	// ram interface sub-registers carry no reset
	always_ff @(posedge mclk) begin
		if (wr_ptr) begin
			ptr_reg <= req.data[PTR_W-1:0];
		end
		if (wr_low) begin
			low_reg <= req.data[BYTE_W-1:0];
		end
		if (wr_high) begin
			high_reg <= req.data[BYTE_W-1:0];
		end
	end

	// serial write wins a same-cycle clash with the processor
	always_ff @(posedge mclk) begin
		if (wr_xword) begin
			xword_reg <= req.data[XWORD_W-1:0];
		end else if (vp_xword_we) begin
			xword_reg <= vp_xword_wdata;
		end
	end

	// each byte read returns the word fetched by the previous one
	always_ff @(posedge mclk) begin
		if (rd_byte) begin
			lag_reg <= mem[ptr_reg];
		end
	end

	// byte lanes of the addressed word, gated by voice power
	always_ff @(posedge mclk) begin
		if (wr_low && mem_wr_ok) begin
			mem[ptr_reg][BYTE_W-1:0] <= req.data[BYTE_W-1:0];
		end
		if (wr_high && mem_wr_ok) begin
			mem[ptr_reg][INSTR_W-1:BYTE_W] <= req.data[BYTE_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		vp_instr <= mem[vp_fetch_addr];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			vp_xword <= '0;
		end else begin
			vp_xword <= wr_xword ? req.data[XWORD_W-1:0] :
				vp_xword_we ? vp_xword_wdata : xword_reg;
		end
	end

	// restart pulse when the voice path leaves the all-off state
	always_ff @(posedge mclk) begin
		if (rst) begin
			voice_was_on_reg <= 1'b0;
			vp_restart       <= 1'b0;
		end else begin
			voice_was_on_reg <= voice_on;
			vp_restart       <= voice_on & ~voice_was_on_reg;
		end
	end

	// enables; baseband paths also follow the external pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			section_en <= POWER_RESET;
		end else begin
			section_en <= power_reg & {SECTIONS{dev_on}};
			section_en[SEC_BB_RX] <= power_reg[SEC_BB_RX] | receive_on_pin;
			section_en[SEC_BB_TX] <= power_reg[SEC_BB_TX] | transmit_on_pin;
			section_en[SEC_DEVICE] <= dev_on;
		end
	end

	// gain decode: multiplier in units of 1/32
	wire [GAIN_W-1:0] codes [STAGES];
	assign codes[0] = gains.mic_cal;
	assign codes[1] = gains.ear_cal;
	assign codes[2] = gains.volume;
	assign codes[3] = gains.sidetone;

	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : gain_stage
			// calibration stages step by 1/16, volume stages by 1/32
			wire [MULT_W-1:0] mult = (g < 2) ? {codes[g], 1'b0} :
				{1'b0, codes[g]};
			always_ff @(posedge mclk) begin
				if (rst) begin
					stage_on[g] <= 1'b0;
					stage_mult[g*MULT_W +: MULT_W] <= '0;
				end else begin
					stage_on[g] <= |codes[g];
					stage_mult[g*MULT_W +: MULT_W] <= mult;
				end
			end
		end
	endgenerate
endmodule // codec_power_instruction_memory
`default_nettype wire

// ---- logic/codec_regs_pkg.sv ----
// shared constants and types for the power and instruction memory registers
package codec_regs_pkg;
	localparam logic [3:0] ADDR_POWER = 4'hC;
	localparam logic [3:0] ADDR_RAMIF = 4'hD;
	localparam logic [3:0] PSUB_GAIN_DAC = 4'h1;
	localparam logic [3:0] PSUB_FREQ_DAC = 4'h2;
	localparam logic [3:0] PSUB_RAMP_DAC = 4'h3;
	localparam logic [3:0] PSUB_VOICE_TX = 4'h4;
	localparam logic [3:0] PSUB_VOICE_RX = 4'h5;
	localparam logic [3:0] PSUB_REF      = 4'h6;
	localparam logic [3:0] PSUB_BB_RX    = 4'h8;
	localparam logic [3:0] PSUB_BB_TX    = 4'h9;
	localparam logic [3:0] PSUB_DEVICE   = 4'hF;
	localparam int PSUB_MSB = 11;
	localparam int PSUB_LSB = 8;
	localparam int POWER_BIT = 0;
	localparam logic [1:0] RSUB_LOW   = 2'h0;
	localparam logic [1:0] RSUB_HIGH  = 2'h1;
	localparam logic [1:0] RSUB_PTR   = 2'h2;
	localparam logic [1:0] RSUB_XWORD = 2'h3;
	localparam int RSUB_MSB = 11;
	localparam int RSUB_LSB = 10;
	localparam int BYTE_W  = 8;
	localparam int PTR_W   = 9;
	localparam int XWORD_W = 10;
	localparam int INSTR_W = 16;
	localparam int MEM_DEPTH = 512;
	localparam int GAIN_W = 6;
	localparam int MULT_W = 7;
	localparam int STAGES = 4;
	// section order in the power vector
	localparam int SEC_GAIN_DAC = 0;
	localparam int SEC_FREQ_DAC = 1;
	localparam int SEC_RAMP_DAC = 2;
	localparam int SEC_VOICE_TX = 3;
	localparam int SEC_VOICE_RX = 4;
	localparam int SEC_REF      = 5;
	localparam int SEC_BB_RX    = 6;
	localparam int SEC_BB_TX    = 7;
	localparam int SEC_DEVICE   = 8;
	localparam int SECTIONS     = 9;
	localparam logic [8:0] POWER_RESET = 9'h122;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  addr;
		logic [11:0] data;
	} serial_req_s;

	typedef struct packed {
		logic [GAIN_W-1:0] mic_cal;
		logic [GAIN_W-1:0] ear_cal;
		logic [GAIN_W-1:0] volume;
		logic [GAIN_W-1:0] sidetone;
	} gain_codes_s;
endpackage

// ---- verif/codec_power_instruction_memory_checker.sv ----
// port assertions for the power and instruction memory registers
`timescale 1ns/1ps
`default_nettype none
module codec_power_instruction_memory_checker
	import codec_regs_pkg::*;
(
	input wire logic                     mclk,
	input wire logic                     rst,
	input wire serial_req_s              req,
	input wire logic                     rd_valid,
	input wire logic [11:0]              rd_data,
	input wire gain_codes_s              gains,
	input wire logic [STAGES-1:0]        stage_on,
	input wire logic [STAGES*MULT_W-1:0] stage_mult,
	input wire logic                     receive_on_pin,
	input wire logic [SECTIONS-1:0]      section_en,
	input wire logic                     vp_restart
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire rd_req = req.valid && !req.write;
	wire pw_wr = req.valid && req.write && req.addr == ADDR_POWER;
	a_read_answer: assert property (rd_req |=> rd_valid)
		else $error("read without answer");
	a_no_stray_read: assert property
		(!rd_req |=> !rd_valid && rd_data == 12'h000)
		else $error("answer without read");
	a_mute_stage: assert property
		(gains.sidetone == 6'h00 |=> !stage_on[3])
		else $error("zero code not muted");
	a_cal_mult: assert property
		(1'b1 |=> stage_mult[6:0] == {$past(gains.mic_cal), 1'b0})
		else $error("calibration gain wrong");
	a_vol_mult: assert property
		(1'b1 |=> stage_mult[20:14] == {1'b0, $past(gains.volume)})
		else $error("volume gain wrong");
	a_bb_or_pin: assert property
		(receive_on_pin [*2] |=> section_en[SEC_BB_RX])
		else $error("receive pin ignored");
	a_restart_cause: assert property
		($rose(vp_restart) |-> $past(pw_wr, 2))
		else $error("restart without power write");
	a_restart_pulse: assert property
		(vp_restart |=> !vp_restart)
		else $error("restart too long");
	c_read: cover property (rd_valid);
	c_restart: cover property (vp_restart);
	c_mute: cover property (stage_on == 4'h0);
endmodule // codec_power_instruction_memory_checker
bind codec_power_instruction_memory codec_power_instruction_memory_checker i_codec_power_instruction_memory_checker (
	.mclk, .rst, .req, .rd_valid, .rd_data, .gains, .stage_on, .stage_mult,
	.receive_on_pin, .section_en, .vp_restart);
`default_nettype wire

// ---- verif/host_ctrl.sv ----
// host controller model issuing decoded serial frames
`timescale 1ns/1ps
`default_nettype none
module host_ctrl
	import codec_regs_pkg::*;
(
	input  wire logic      mclk,
	output var serial_req_s req
);
	initial req = '0;
	// fields scrambled once the frame is taken
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [11:0] d);
		@(posedge mclk) req <= '{1'b1, w, a, d};
		@(posedge mclk) req <= '{1'b0, ~w, ~a, ~d};
	endtask
	task automatic load(input logic [8:0] p, input logic [15:0] v);
		xfer(1'b1, ADDR_RAMIF, {RSUB_PTR, 1'b0, p});
		xfer(1'b1, ADDR_RAMIF, {RSUB_HIGH, 2'b00, v[15:8]});
		xfer(1'b1, ADDR_RAMIF, {RSUB_LOW, 2'b00, v[7:0]});
	endtask
endmodule // host_ctrl
`default_nettype wire

// ---- verif/tb_codec_power_instruction_memory.sv ----
// self-checking bench for the power and instruction memory registers
`timescale 1ns/1ps
`default_nettype none
module tb_codec_power_instruction_memory
	import codec_regs_pkg::*;
;
	logic        mclk = 1'b0, rd_valid, vp_restart;
	logic        rst = 1'b1, rxp = 1'b0, txp = 1'b0, xwe = 1'b0;
	logic [8:0]  fetch = 9'h000, flags = POWER_RESET, section_en, p [3];
	logic [9:0]  xwd = 10'h000, vp_xword, x;
	logic [11:0] rd_data, q;
	logic [15:0] vp_instr, w [3];
	logic [3:0]  stage_on;
	logic [27:0] stage_mult;
	gain_codes_s gains = '0, g;
	serial_req_s req;
	int          n_errors = 0, cmp_count = 0, seed = 22;
	int          sec_of [16] = '{-1, 0, 1, 2, 3, 4, 5, -1, 6, 7,
		-1, -1, -1, -1, -1, 8};
	codec_power_instruction_memory i_codec_power_instruction_memory (.mclk, .rst, .req, .rd_valid,
		.rd_data, .gains, .stage_on, .stage_mult, .receive_on_pin(rxp),
		.transmit_on_pin(txp), .section_en, .vp_fetch_addr(fetch),
		.vp_instr, .vp_xword_we(xwe), .vp_xword_wdata(xwd), .vp_xword,
		.vp_restart);
	host_ctrl i_host_ctrl (.mclk, .req);
	initial forever #2 mclk = ~mclk;
	task automatic chk(input string n, input logic [27:0] e, s);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rd(input logic [3:0] a, input logic [11:0] d);
		i_host_ctrl.xfer(1'b0, a, d);
		#1 chk("rd_valid", 1'b1, rd_valid);
		q = rd_data;
	endtask
	task automatic pw(input logic [3:0] s, input logic b);
		logic [8:0] o;
		o = flags;
		@(posedge mclk) {rxp, txp} <= 2'($random(seed));
		i_host_ctrl.xfer(1'b1, ADDR_POWER, {s, 7'($random(seed)), b});
		if (sec_of[s] >= 0) flags[sec_of[s]] = b;
		@(posedge mclk) #1;
		chk("section_en", {flags[8], flags[7] | txp, flags[6] | rxp,
			flags[5:0] & {6{flags[8]}}}, section_en);
		chk("vp_restart", o[4:3] == 2'b00 && |flags[4:3], vp_restart);
	endtask
	initial begin
		#100000;
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk) #1;
		chk("section_en", POWER_RESET, section_en);
		for (int i = 0; i < 24; i++) begin
			g = i == 0 ? 24'h000000 : i == 1 ? 24'h820820
				: i == 2 ? 24'hFFF03F : 24'($random(seed));
			if (&{g.ear_cal, g.volume, g.sidetone}) g.sidetone = 6'h00;
			@(posedge mclk) gains <= g;
			@(posedge mclk) #1;
			chk("stage_on", {|g.sidetone, |g.volume, |g.ear_cal,
				|g.mic_cal}, stage_on);
			chk("stage_mult", {1'b0, g.sidetone, 1'b0, g.volume, g.ear_cal,
				1'b0, g.mic_cal, 1'b0}, stage_mult);
		end
		for (int i = 0; i < 40; i++)
			pw(i < 16 ? 4'(i) : 4'($random(seed)), 1'($random(seed)));
		pw(4'hF, 1'b1);
		pw(4'h4, 1'b0);
		pw(4'h5, 1'b0);
		for (int i = 0; i < 3; i++) begin
			p[i] = {7'($random(seed)), 2'(i)};
			w[i] = 16'($random(seed));
			i_host_ctrl.load(p[i], w[i]);
		end
		for (int i = 0; i < 4; i++) begin
			i_host_ctrl.xfer(1'b1, ADDR_RAMIF, {RSUB_PTR, 1'b0, p[i % 3]});
			rd(ADDR_RAMIF, {i[0] ? RSUB_HIGH : RSUB_LOW, 10'h000});
			if (i > 0) // first byte read is undefined
				chk("mem_byte", i[0] ? w[i-1][15:8] : w[i-1][7:0], q[7:0]);
		end
		rd(ADDR_RAMIF, {RSUB_PTR, 10'h000});
		chk("pointer", {3'b000, p[0]}, q);
		pw(4'h5, 1'b1);
		i_host_ctrl.load(p[1], ~w[1]);
		@(posedge mclk) fetch <= p[1];
		@(posedge mclk) #1;
		chk("vp_instr", w[1], vp_instr);
		x = 10'($random(seed));
		i_host_ctrl.xfer(1'b1, ADDR_RAMIF, {RSUB_XWORD, x});
		#1 chk("vp_xword", x, vp_xword);
		@(posedge mclk) {xwe, xwd} <= {1'b1, ~x};
		@(posedge mclk) xwe <= 1'b0;
		rd(ADDR_RAMIF, {RSUB_XWORD, 10'h000});
		chk("xword", {2'b00, ~x}, q);
		for (int i = 0; i < 2; i++) begin
			rd(i ? ADDR_POWER : 4'($random(seed)) & 4'hB, 12'hFFF);
			chk("rd_zero", '0, q);
		end
		finish_test;
	end
endmodule // tb_codec_power_instruction_memory
`default_nettype wire
